// ### rtl/olaf_pkg.sv
/*
 * Constants for the output level and serial port format register bank:
 * register offsets, field positions, masks, reset values and codes.
 * Assumes a 16-bit control word interface with an 8-bit register address.
 */
package olaf_pkg;
    // Register offsets
    localparam logic [7:0]  ADDR_LEFT_LEVEL  = 8'h6A;
    localparam logic [7:0]  ADDR_RIGHT_LEVEL = 8'h6B;
    localparam logic [7:0]  ADDR_TONE_MIX    = 8'h6F;
    localparam logic [7:0]  ADDR_PORT_FMT    = 8'h70;

    // Channel register fields
    localparam int          BIT_DRIVER_ON    = 15;
    localparam int          BIT_SILENCE      = 14;
    localparam int          BIT_ZERO_CROSS   = 13;
    localparam int          BIT_INVERTER_ON  = 10;
    localparam int          BIT_FEED_SELECT  = 9;
    localparam int          BIT_COMMIT       = 8;
    localparam int          LEVEL_LSB        = 2;
    localparam int          LEVEL_W          = 6;

    // Tone mixer fields
    localparam int          BIT_TONE_ON      = 15;
    localparam int          TONE_LSB         = 5;
    localparam int          TONE_W           = 3;

    // Format register fields
    localparam int          BIT_BCLK_INV     = 15;
    localparam int          BIT_FLOAT        = 13;
    localparam int          BIT_FRAME_INV    = 12;
    localparam int          WL_LSB           = 10;
    localparam int          FMT_LSB          = 8;

    // Writable bit masks; everything else reads zero
    localparam logic [15:0] MASK_LEFT        = 16'hE0FC;
    localparam logic [15:0] MASK_RIGHT       = 16'hE6FC;
    localparam logic [15:0] MASK_TONE        = 16'h80E0;
    localparam logic [15:0] MASK_FMT         = 16'hBF00;

    // Reset values
    localparam logic [15:0] RST_LEFT         = 16'h00E4;
    localparam logic [15:0] RST_RIGHT        = 16'h02E4;
    localparam logic [15:0] RST_TONE         = 16'h0000;
    localparam logic [15:0] RST_FMT          = 16'h0A00;
    localparam logic [5:0]  LEVEL_0DB        = 6'h39;

    // Word length and frame format codes
    localparam logic [1:0]  WL_16            = 2'h0;
    localparam logic [1:0]  WL_20            = 2'h1;
    localparam logic [1:0]  WL_24            = 2'h2;
    localparam logic [1:0]  WL_32            = 2'h3;
    localparam logic [1:0]  FMT_RIGHT_JUST   = 2'h0;
    localparam logic [1:0]  FMT_LEFT_JUST    = 2'h1;
    localparam logic [1:0]  FMT_I2S          = 2'h2;
    localparam logic [1:0]  FMT_DSP          = 2'h3;

    // Bit clock edges from frame clock rise to MSB in DSP format
    localparam logic [1:0]  MSB_EDGE_MODE_A  = 2'h2;
    localparam logic [1:0]  MSB_EDGE_MODE_B  = 2'h1;
    localparam logic [1:0]  MSB_EDGE_NONE    = 2'h0;
endpackage

// ### rtl/olaf_regs.sv
/*
 * Second output pair level registers, tone mixer level and serial port
 * format register, with the deferred pair commit and zero-cross gating.
 * Assumes a synchronous write/read strobe port from the control interface
 * and zero-crossing pulses from the analogue output path.
 */
`timescale 1ns/1ps
module olaf_regs (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_addr,
    input  wire logic        left_zero_seen,
    input  wire logic        right_zero_seen,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             left_driver_on,
    output logic             left_silence,
    output logic             left_zero_cross_gate,
    output logic      [5:0]  left_gain,
    output logic             right_driver_on,
    output logic             right_silence,
    output logic             right_zero_cross_gate,
    output logic      [5:0]  right_gain,
    output logic             right_inverter_on,
    output logic             right_inverter_feed_select,
    output logic             tone_mix_on,
    output logic      [2:0]  tone_mix_level_code,
    output logic             bit_clock_invert,
    output logic             frame_clock_invert,
    output logic      [1:0]  frame_format_select,
    output logic      [1:0]  word_length_select,
    output logic      [1:0]  word_length_eff,
    output logic      [1:0]  msb_edge,
    output logic             port_pins_oe
);
    logic [15:0] left_r;
    logic [15:0] right_r;
    logic [15:0] tone_r;
    logic [15:0] fmt_r;
    logic [15:0] left_nxt;
    logic [15:0] right_nxt;
    logic [15:0] tone_nxt;
    logic [15:0] fmt_nxt;
    logic [5:0]  left_gain_r;
    logic [5:0]  right_gain_r;
    logic [5:0]  left_target_r;
    logic [5:0]  right_target_r;
    logic        left_wait_r;
    logic        right_wait_r;
    logic [15:0] rd_data_r;
    logic        rd_valid_r;
    logic [1:0]  wl_eff_r;
    logic [1:0]  msb_edge_r;
    logic        pins_oe_r;

    // Address decode for writes
    wire         wr_left  = wr_en && (wr_addr == olaf_pkg::ADDR_LEFT_LEVEL);
    wire         wr_right = wr_en && (wr_addr == olaf_pkg::ADDR_RIGHT_LEVEL);
    wire         wr_tone  = wr_en && (wr_addr == olaf_pkg::ADDR_TONE_MIX);
    wire         wr_fmt   = wr_en && (wr_addr == olaf_pkg::ADDR_PORT_FMT);

    // Only defined bits are stored, so reserved bits neither steer nor read back
    assign left_nxt  = wr_left  ? (wr_data & olaf_pkg::MASK_LEFT)  : left_r;
    assign right_nxt = wr_right ? (wr_data & olaf_pkg::MASK_RIGHT) : right_r;
    assign tone_nxt  = wr_tone  ? (wr_data & olaf_pkg::MASK_TONE)  : tone_r;
    assign fmt_nxt   = wr_fmt   ? (wr_data & olaf_pkg::MASK_FMT)   : fmt_r;

    // Commit bit is an action, not storage; either register commits the pair
    wire         commit = (wr_left || wr_right) && wr_data[olaf_pkg::BIT_COMMIT];

    wire [5:0]   left_level_nxt  = left_nxt[olaf_pkg::LEVEL_LSB +: olaf_pkg::LEVEL_W];
    wire [5:0]   right_level_nxt = right_nxt[olaf_pkg::LEVEL_LSB +: olaf_pkg::LEVEL_W];
    wire         left_zc_nxt     = left_nxt[olaf_pkg::BIT_ZERO_CROSS];
    wire         right_zc_nxt    = right_nxt[olaf_pkg::BIT_ZERO_CROSS];

    // Derived serial port settings from the next format value
    wire [1:0]   fmt_sel_nxt = fmt_nxt[olaf_pkg::FMT_LSB +: 2];
    wire [1:0]   wl_sel_nxt  = fmt_nxt[olaf_pkg::WL_LSB +: 2];
    wire         frame_b_nxt = fmt_nxt[olaf_pkg::BIT_FRAME_INV];
    wire         rj_too_long = (fmt_sel_nxt == olaf_pkg::FMT_RIGHT_JUST)
                               && (wl_sel_nxt == olaf_pkg::WL_32);
    wire [1:0]   wl_eff_nxt  = rj_too_long ? olaf_pkg::WL_24 : wl_sel_nxt;
    wire [1:0]   msb_nxt     = (fmt_sel_nxt != olaf_pkg::FMT_DSP) ? olaf_pkg::MSB_EDGE_NONE
                             : frame_b_nxt ? olaf_pkg::MSB_EDGE_MODE_B
                             : olaf_pkg::MSB_EDGE_MODE_A;

    // Read mux; unmapped offsets answer zero
    wire [15:0]  rd_mux = (rd_addr == olaf_pkg::ADDR_LEFT_LEVEL)  ? left_r
                        : (rd_addr == olaf_pkg::ADDR_RIGHT_LEVEL) ? right_r
                        : (rd_addr == olaf_pkg::ADDR_TONE_MIX)    ? tone_r
                        : (rd_addr == olaf_pkg::ADDR_PORT_FMT)    ? fmt_r
                        : 16'h0000;

    // Register storage with documented reset values
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            left_r  <= olaf_pkg::RST_LEFT;
            right_r <= olaf_pkg::RST_RIGHT;
            tone_r  <= olaf_pkg::RST_TONE;
            fmt_r   <= olaf_pkg::RST_FMT;
        end else begin
            left_r  <= left_nxt;
            right_r <= right_nxt;
            tone_r  <= tone_nxt;
            fmt_r   <= fmt_nxt;
        end
    end

    // Commit snapshots both pending levels; written levels never reach gain alone
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            left_target_r  <= olaf_pkg::LEVEL_0DB;
            right_target_r <= olaf_pkg::LEVEL_0DB;
        end else if (commit) begin
            left_target_r  <= left_level_nxt;
            right_target_r <= right_level_nxt;
        end
    end

    // Left gain: immediate or held for a zero crossing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            left_gain_r <= olaf_pkg::LEVEL_0DB;
            left_wait_r <= 1'b0;
        end else if (commit) begin
            if (!left_zc_nxt) begin
                left_gain_r <= left_level_nxt;
            end
            left_wait_r <= left_zc_nxt;
        end else if (left_wait_r && (left_zero_seen || !left_zc_nxt)) begin
            left_gain_r <= left_target_r;
            left_wait_r <= 1'b0;
        end
    end

    // Right gain: same gating as the left channel
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            right_gain_r <= olaf_pkg::LEVEL_0DB;
            right_wait_r <= 1'b0;
        end else if (commit) begin
            if (!right_zc_nxt) begin
                right_gain_r <= right_level_nxt;
            end
            right_wait_r <= right_zc_nxt;
        end else if (right_wait_r && (right_zero_seen || !right_zc_nxt)) begin
            right_gain_r <= right_target_r;
            right_wait_r <= 1'b0;
        end
    end

    // Serial port derived controls, registered so outputs come from flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wl_eff_r   <= olaf_pkg::WL_24;
            msb_edge_r <= olaf_pkg::MSB_EDGE_NONE;
            pins_oe_r  <= 1'b1;
        end else begin
            wl_eff_r   <= wl_eff_nxt;
            msb_edge_r <= msb_nxt;
            pins_oe_r  <= !fmt_nxt[olaf_pkg::BIT_FLOAT];
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data_r  <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r  <= rd_en ? rd_mux : 16'h0000;
            rd_valid_r <= rd_en;
        end
    end

    // Output mapping straight from flops
    assign rd_data                    = rd_data_r;
    assign rd_valid                   = rd_valid_r;
    assign left_driver_on             = left_r[olaf_pkg::BIT_DRIVER_ON];
    assign left_silence               = left_r[olaf_pkg::BIT_SILENCE];
    assign left_zero_cross_gate       = left_r[olaf_pkg::BIT_ZERO_CROSS];
    assign left_gain                  = left_gain_r;
    assign right_driver_on            = right_r[olaf_pkg::BIT_DRIVER_ON];
    assign right_silence              = right_r[olaf_pkg::BIT_SILENCE];
    assign right_zero_cross_gate      = right_r[olaf_pkg::BIT_ZERO_CROSS];
    assign right_gain                 = right_gain_r;
    assign right_inverter_on          = right_r[olaf_pkg::BIT_INVERTER_ON];
    assign right_inverter_feed_select = right_r[olaf_pkg::BIT_FEED_SELECT];
    assign tone_mix_on                = tone_r[olaf_pkg::BIT_TONE_ON];
    assign tone_mix_level_code        = tone_r[olaf_pkg::TONE_LSB +: olaf_pkg::TONE_W];
    assign bit_clock_invert           = fmt_r[olaf_pkg::BIT_BCLK_INV];
    assign frame_clock_invert         = fmt_r[olaf_pkg::BIT_FRAME_INV];
    assign frame_format_select        = fmt_r[olaf_pkg::FMT_LSB +: 2];
    assign word_length_select         = fmt_r[olaf_pkg::WL_LSB +: 2];
    assign word_length_eff            = wl_eff_r;
    assign msb_edge                   = msb_edge_r;
    assign port_pins_oe               = pins_oe_r;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_left_zc_commit;
        commit && left_zc_nxt;
    endsequence

    sequence s_left_zero_hit;
        left_wait_r && left_zero_seen && left_zero_cross_gate && !commit;
    endsequence

    a_reset_defaults: assert property ($past(sys_rst) |->
        !left_driver_on && !right_silence && left_gain == olaf_pkg::LEVEL_0DB
        && right_inverter_feed_select && !right_inverter_on)
        else $error("reset values wrong");
    a_gain_immediate: assert property (commit && !left_zc_nxt |=>
        left_gain == $past(left_level_nxt))
        else $error("gain not applied at once");
    a_gain_zc_hold: assert property (s_left_zc_commit ##1 !left_zero_seen && !commit
        && left_zc_nxt |=> left_gain == $past(left_gain, 2))
        else $error("gain changed before zero cross");
    a_gain_zc_apply: assert property (s_left_zero_hit |=>
        left_gain == $past(left_target_r) && !left_wait_r)
        else $error("gain not applied on zero cross");
    a_pending_level: assert property (wr_left && !wr_data[olaf_pkg::BIT_COMMIT]
        && !left_wait_r |=> left_gain == $past(left_gain))
        else $error("level applied without commit");
    a_pair_commit: assert property (wr_right && wr_data[olaf_pkg::BIT_COMMIT] |=>
        left_target_r == $past(left_level_nxt) && right_target_r == $past(right_level_nxt))
        else $error("pair not committed together");
    a_float_pins: assert property (wr_fmt |=>
        port_pins_oe == !$past(wr_data[olaf_pkg::BIT_FLOAT]))
        else $error("pin float control wrong");
    a_dsp_mode_a: assert property (frame_format_select == olaf_pkg::FMT_DSP
        && !frame_clock_invert |-> msb_edge == olaf_pkg::MSB_EDGE_MODE_A)
        else $error("mode A MSB edge wrong");
    a_dsp_mode_b: assert property (frame_format_select == olaf_pkg::FMT_DSP
        && frame_clock_invert |-> msb_edge == olaf_pkg::MSB_EDGE_MODE_B)
        else $error("mode B MSB edge wrong");
    a_rj_word_cap: assert property (frame_format_select == olaf_pkg::FMT_RIGHT_JUST
        |-> word_length_eff != olaf_pkg::WL_32)
        else $error("right-justified word too long");
    a_reserved_zero: assert property (rd_en && rd_addr == olaf_pkg::ADDR_RIGHT_LEVEL
        |=> (rd_data & ~olaf_pkg::MASK_RIGHT) == 16'h0000)
        else $error("reserved bits read nonzero");
endmodule

// ### verification/olaf_testbench.sv
/*
 * Self-checking bench for the output level and serial port format register bank.
 * Assumes the olaf_regs strobe ports: a request is taken one edge after it is driven,
 * fields show one cycle after the write edge, read data one cycle after the read edge.
 */
`timescale 1ns/1ps
module testbench;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wr_en = 1'b0;
    logic [7:0]  wr_addr = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic        rd_en = 1'b0;
    logic [7:0]  rd_addr = 8'h00;
    logic        left_zero_seen = 1'b0;
    logic        right_zero_seen = 1'b0;
    logic [15:0] rd_data;
    logic        rd_valid, left_driver_on, left_silence, left_zero_cross_gate;
    logic        right_driver_on, right_silence, right_zero_cross_gate;
    logic [5:0]  left_gain, right_gain;
    logic        right_inverter_on, right_inverter_feed_select, tone_mix_on;
    logic [2:0]  tone_mix_level_code;
    logic        bit_clock_invert, frame_clock_invert, port_pins_oe;
    logic [1:0]  frame_format_select, word_length_select, word_length_eff, msb_edge;
    int          failures = 0;
    int          compares = 0;
    int          cycles = 0;

    olaf_regs olaf_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .left_zero_seen(left_zero_seen), .right_zero_seen(right_zero_seen),
        .rd_data(rd_data), .rd_valid(rd_valid), .left_driver_on(left_driver_on),
        .left_silence(left_silence), .left_zero_cross_gate(left_zero_cross_gate),
        .left_gain(left_gain), .right_driver_on(right_driver_on),
        .right_silence(right_silence), .right_zero_cross_gate(right_zero_cross_gate),
        .right_gain(right_gain), .right_inverter_on(right_inverter_on),
        .right_inverter_feed_select(right_inverter_feed_select), .tone_mix_on(tone_mix_on),
        .tone_mix_level_code(tone_mix_level_code), .bit_clock_invert(bit_clock_invert),
        .frame_clock_invert(frame_clock_invert), .frame_format_select(frame_format_select),
        .word_length_select(word_length_select), .word_length_eff(word_length_eff),
        .msb_edge(msb_edge), .port_pins_oe(port_pins_oe));

    // 100 MHz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // Cycle ceiling well above the under two hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            $display("Error at %0t: timeout", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Drive at one edge, taken at the next; the gap edge keeps strobes single-assigned
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(16'(rd_valid), 16'h0001);
        d = rd_data;
    endtask

    task automatic t_reset();
        logic [15:0] d;
        rd(olaf_pkg::ADDR_LEFT_LEVEL, d);
        chk(d, olaf_pkg::RST_LEFT);
        rd(olaf_pkg::ADDR_RIGHT_LEVEL, d);
        chk(d, olaf_pkg::RST_RIGHT);
        rd(olaf_pkg::ADDR_TONE_MIX, d);
        chk(d, olaf_pkg::RST_TONE);
        rd(olaf_pkg::ADDR_PORT_FMT, d);
        chk(d, olaf_pkg::RST_FMT);
        chk(16'({left_gain, right_gain}), 16'({6'h39, 6'h39}));
        chk(16'({port_pins_oe, word_length_eff, msb_edge}), 16'h0018);
        $display("done t_reset");
    endtask

    task automatic t_fields();
        logic [15:0] d;
        wr(olaf_pkg::ADDR_LEFT_LEVEL, 16'hC0E4);
        wr(olaf_pkg::ADDR_RIGHT_LEVEL, 16'hC4E4);
        chk(16'({left_driver_on, left_silence, right_driver_on, right_silence}), 16'hF);
        chk(16'({right_inverter_on, right_inverter_feed_select}), 16'h2);
        rd(olaf_pkg::ADDR_RIGHT_LEVEL, d);
        chk(d, 16'hC4E4);
        wr(olaf_pkg::ADDR_LEFT_LEVEL, 16'h0000);
        wr(olaf_pkg::ADDR_RIGHT_LEVEL, 16'h0000);
        chk(16'({left_driver_on, left_silence, right_inverter_on}), 16'h0);
        $display("done t_fields");
    endtask

    task automatic t_commit();
        logic [15:0] d;
        wr(olaf_pkg::ADDR_LEFT_LEVEL, 16'h0014);
        chk(16'(left_gain), 16'h0039);
        wr(olaf_pkg::ADDR_RIGHT_LEVEL, 16'h01FC);
        chk(16'({left_gain, right_gain}), 16'({6'h05, 6'h3F}));
        rd(olaf_pkg::ADDR_RIGHT_LEVEL, d);
        chk(d, 16'h00FC);
        wr(olaf_pkg::ADDR_LEFT_LEVEL, 16'h0100);
        chk(16'({left_gain, right_gain}), 16'({6'h00, 6'h3F}));
        $display("done t_commit");
    endtask

    task automatic t_zero();
        wr(olaf_pkg::ADDR_RIGHT_LEVEL, 16'h0080);
        wr(olaf_pkg::ADDR_LEFT_LEVEL, 16'h2140);
        chk(16'({left_zero_cross_gate, right_gain}), 16'({1'b1, 6'h20}));
        repeat (3) @(posedge core_clk);
        right_zero_seen <= 1'b1;
        @(posedge core_clk);
        right_zero_seen <= 1'b0;
        left_zero_seen  <= 1'b1;
        #1;
        chk(16'(left_gain), 16'h0000);
        @(posedge core_clk);
        left_zero_seen <= 1'b0;
        #1;
        chk(16'(left_gain), 16'h0010);
        wr(olaf_pkg::ADDR_LEFT_LEVEL, 16'h0000);
        // Right channel waits on its own crossing; left applies at once
        wr(olaf_pkg::ADDR_RIGHT_LEVEL, 16'h2108);
        chk(16'({right_zero_cross_gate, right_gain}), 16'({1'b1, 6'h20}));
        chk(16'(left_gain), 16'h0000);
        @(posedge core_clk);
        right_zero_seen <= 1'b1;
        @(posedge core_clk);
        right_zero_seen <= 1'b0;
        #1;
        chk(16'(right_gain), 16'h0002);
        wr(olaf_pkg::ADDR_RIGHT_LEVEL, 16'h0000);
        $display("done t_zero");
    endtask

    task automatic t_unmapped();
        logic [15:0] d;
        wr(8'h6C, 16'hFFFF);
        rd(8'h6C, d);
        chk(d, 16'h0000);
        rd(olaf_pkg::ADDR_LEFT_LEVEL, d);
        chk(d, 16'h0000);
        wr(olaf_pkg::ADDR_TONE_MIX, 16'hFFFF);
        rd(olaf_pkg::ADDR_TONE_MIX, d);
        chk(d, olaf_pkg::MASK_TONE);
        chk(16'({tone_mix_on, tone_mix_level_code}), 16'h000F);
        $display("done t_unmapped");
    endtask

    // Every format and word length code; bit 14 and the low byte are undefined
    task automatic t_format();
        logic [15:0] v, d;
        logic [1:0]  f, w, e, m;
        for (int i = 0; i < 16; i++) begin
            f = 2'(i);
            w = 2'(i >> 2);
            v = {f[0], 1'b1, 1'b0, w[0], w, f, 8'hFF};
            e = (f == olaf_pkg::FMT_RIGHT_JUST && w == olaf_pkg::WL_32) ? olaf_pkg::WL_24 : w;
            m = (f != olaf_pkg::FMT_DSP) ? olaf_pkg::MSB_EDGE_NONE :
                (w[0] ? olaf_pkg::MSB_EDGE_MODE_B : olaf_pkg::MSB_EDGE_MODE_A);
            wr(olaf_pkg::ADDR_PORT_FMT, v);
            chk(16'({bit_clock_invert, frame_clock_invert}), 16'({f[0], w[0]}));
            chk(16'({frame_format_select, word_length_select}), 16'({f, w}));
            chk(16'({word_length_eff, msb_edge}), 16'({e, m}));
            rd(olaf_pkg::ADDR_PORT_FMT, d);
            chk(d, v & olaf_pkg::MASK_FMT);
        end
        wr(olaf_pkg::ADDR_PORT_FMT, 16'h2A00);
        chk(16'(port_pins_oe), 16'h0000);
        wr(olaf_pkg::ADDR_PORT_FMT, olaf_pkg::RST_FMT);
        chk(16'(port_pins_oe), 16'h0001);
        $display("done t_format");
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        t_reset();
        t_fields();
        t_commit();
        t_zero();
        t_unmapped();
        t_format();
        final_report();
    end
endmodule
